//--- pqtc_ctrl_if.sv
`timescale 1ns/1ps
interface pqtc_ctrl_if;
   logic storm_en;
   logic dscp_en;
   logic vlanprio_en;
   logic port_high;
   logic prio_ceiling;
   logic tag_add;
   logic tag_strip;
   logic dual_queue;

   modport src (
      output storm_en,
      output dscp_en,
      output vlanprio_en,
      output port_high,
      output prio_ceiling,
      output tag_add,
      output tag_strip,
      output dual_queue
   );

   modport dst (
      input storm_en,
      input dscp_en,
      input vlanprio_en,
      input port_high,
      input prio_ceiling,
      input tag_add,
      input tag_strip,
      input dual_queue
   );
endinterface : pqtc_ctrl_if

//--- pqtc_ing_cls.sv
`timescale 1ns/1ps
module pqtc_ing_cls (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   pqtc_ctrl_if.dst ctrl,
   input wire logic i_valid,
   input wire logic i_tagged,
   input wire logic i_is_ip,
   input wire logic i_dscp_high,
   input wire logic [2:0] i_user_prio,
   input wire logic [2:0] i_dflt_prio,
   output logic o_valid,
   output logic o_high,
   output logic [2:0] o_user_prio
);

   logic [2:0] next_prio;
   logic dscp_yield;
   logic vlan_yield;
   logic vlan_high;
   logic next_high;

   // Priority ceiling against the default tag
   always_comb begin
      if (ctrl.prio_ceiling && (i_user_prio > i_dflt_prio)) begin
         next_prio = i_dflt_prio;
      end else begin
         next_prio = i_user_prio;
      end
   end

   // Class decision
   always_comb begin
      dscp_yield = ctrl.dscp_en && i_is_ip;
      vlan_yield = ctrl.vlanprio_en && i_tagged;
      vlan_high = next_prio >= pqtc_pkg::VLANPRIO_HIGH_MIN;
      if (dscp_yield || vlan_yield) begin
         next_high = (dscp_yield && i_dscp_high) || (vlan_yield && vlan_high);
      end else begin
         next_high = ctrl.port_high;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_valid;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_high <= 1'b0;
         o_user_prio <= 3'h0;
      end else if (i_valid) begin
         o_high <= next_high;
         o_user_prio <= next_prio;
      end
   end

endmodule : pqtc_ing_cls

//--- pqtc_pkg.sv
package pqtc_pkg;

   // Number of switch ports served
   localparam int NUM_PORTS = 3;

   // Register map
   localparam logic [7:0] PORT1_QOS_TAG_CTRL_OFFS = 8'h10;
   localparam logic [7:0] PORT2_QOS_TAG_CTRL_OFFS = 8'h20;
   localparam logic [7:0] PORT3_QOS_TAG_CTRL_OFFS = 8'h30;
   localparam logic [2:0][7:0] PORT_CTRL_OFFS = {
      PORT3_QOS_TAG_CTRL_OFFS,
      PORT2_QOS_TAG_CTRL_OFFS,
      PORT1_QOS_TAG_CTRL_OFFS
   };
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   // Field positions of each port control register
   localparam int BIT_STORM_EN = 7;
   localparam int BIT_DSCP_EN = 6;
   localparam int BIT_VLANPRIO_EN = 5;
   localparam int BIT_PORTPRIO = 4;
   localparam int BIT_PRIO_CEILING = 3;
   localparam int BIT_TAG_ADD = 2;
   localparam int BIT_TAG_STRIP = 1;
   localparam int BIT_DUAL_QUEUE = 0;

   // Values after reset for the bits not loaded from straps
   localparam logic RST_STORM_EN = 1'b0;
   localparam logic RST_DSCP_EN = 1'b0;
   localparam logic RST_PRIO_CEILING = 1'b0;

   // Strap vector layout: {vlanprio, portprio, tag_add, tag_strip, dual_queue}
   localparam int STRAP_W = 5;

   // User priority at or above which a tagged frame counts as high
   localparam logic [2:0] VLANPRIO_HIGH_MIN = 3'h4;

   // Widths
   localparam int VID_W = 12;
   localparam int SRC_W = 2;

endpackage : pqtc_pkg

//--- pqtc_props.sv
`timescale 1ns/1ps
module pqtc_props (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic [2:0] i_ing_valid,
   input wire logic [2:0] o_ing_valid,
   input wire logic [2:0] i_eg_valid,
   input wire logic [2:0] i_eg_rx_tagged,
   input wire logic [2:0] o_eg_valid,
   input wire logic [2:0] o_eg_add_tag,
   input wire logic [2:0] o_eg_strip_tag,
   input wire logic [2:0] o_storm_en,
   input wire logic [2:0] o_dual_queue
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");
   AST_RD_ONLY: assert property (o_reg_rvalid |-> $past(i_reg_rd))
      else $error("read valid without read");
   AST_RD_UNMAPPED: assert property (i_reg_rd && !(i_reg_addr inside {8'h10, 8'h20, 8'h30})
      |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_STORM: assert property (i_reg_wr && i_reg_addr == 8'h10
      |-> ##2 o_storm_en[0] == $past(i_reg_wdata[7], 2)) else $error("storm enable wrong");
   AST_DUALQ: assert property (i_reg_wr && i_reg_addr == 8'h30
      |-> ##2 o_dual_queue[2] == $past(i_reg_wdata[0], 2)) else $error("dual queue wrong");
   AST_ING: assert property (i_ing_valid[0] |=> o_ing_valid[0])
      else $error("ingress not answered");
   AST_EG: assert property (i_eg_valid[1] |=> o_eg_valid[1])
      else $error("egress not answered");
   AST_NO_ADD: assert property (i_eg_valid[0] && i_eg_rx_tagged[0] |=> !o_eg_add_tag[0])
      else $error("tag added to tagged frame");
   AST_NO_STRIP: assert property (i_eg_valid[0] && !i_eg_rx_tagged[0] |=> !o_eg_strip_tag[0])
      else $error("strip on untagged frame");
endmodule : pqtc_props
bind pqtc_top pqtc_props u_pqtc_props (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
   .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_ing_valid, .o_ing_valid, .i_eg_valid,
   .i_eg_rx_tagged, .o_eg_valid, .o_eg_add_tag, .o_eg_strip_tag, .o_storm_en, .o_dual_queue);

//--- pqtc_top.sv
// Operation
// - Bit 7 enables ingress broadcast storm limiting
// - Bit 6 enables DSCP priority classification
// - Bit 5 enables 802.1p priority classification
// - Bit 4 gives class when others fail
// - OR of DSCP and 802.1p overrides port
// - Bit 3 caps user priority at default
// - Bit 2 tags untagged egress frames only
// - Inserted tag uses ingress port VID
// - Bit 1 strips tags from tagged egress frames
// - Bit 0 set gives two egress queues
// - Bit 0 clear gives one unclassed queue
// - Same layout at 0x10, 0x20, 0x30
`timescale 1ns/1ps
module pqtc_top (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Management register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Strap pins
   input wire logic i_strap_vlanprio_en_a,
   input wire logic i_strap_vlanprio_en_b,
   input wire logic i_strap_vlanprio_en_c,
   input wire logic i_strap_portprio_a,
   input wire logic i_strap_portprio_b,
   input wire logic i_strap_portprio_c,
   input wire logic i_strap_tag_add_a,
   input wire logic i_strap_tag_add_b,
   input wire logic i_strap_tag_add_c,
   input wire logic i_strap_tag_strip_a,
   input wire logic i_strap_tag_strip_b,
   input wire logic i_strap_tag_strip_c,
   input wire logic i_strap_dual_queue_a,
   input wire logic i_strap_dual_queue_b,
   input wire logic i_strap_dual_queue_c,
   // Per-port default tag fields
   input wire logic [2:0][11:0] i_port_vid,
   input wire logic [2:0][2:0] i_port_dflt_prio,
   // Ingress classification, one lane per port
   input wire logic [2:0] i_ing_valid,
   input wire logic [2:0] i_ing_tagged,
   input wire logic [2:0] i_ing_is_ip,
   input wire logic [2:0] i_ing_dscp_high,
   input wire logic [2:0][2:0] i_ing_user_prio,
   output logic [2:0] o_ing_valid,
   output logic [2:0] o_ing_high,
   output logic [2:0][2:0] o_ing_user_prio,
   output logic [2:0] o_storm_en,
   // Egress tag and queue decision, one lane per output port
   input wire logic [2:0] i_eg_valid,
   input wire logic [2:0][1:0] i_eg_src_port,
   input wire logic [2:0] i_eg_rx_tagged,
   input wire logic [2:0] i_eg_high,
   output logic [2:0] o_eg_valid,
   output logic [2:0] o_eg_add_tag,
   output logic [2:0] o_eg_strip_tag,
   output logic [2:0][11:0] o_eg_vid,
   output logic [2:0] o_eg_queue_high,
   output logic [2:0] o_dual_queue
);

   localparam int NP = pqtc_pkg::NUM_PORTS;
   localparam int SW = pqtc_pkg::STRAP_W;

   logic [NP-1:0][SW-1:0] strap_raw;
   logic [NP-1:0][SW-1:0] strap_s1;
   logic [NP-1:0][SW-1:0] strap_s2;
   logic [NP-1:0][SW-1:0] strap_s3;
   logic [NP-1:0][SW-1:0] strap_stable;
   logic [NP-1:0][7:0] ctrl_reg;
   logic [NP-1:0] hit;
   logic [7:0] next_rdata;

   pqtc_ctrl_if u_ctrl [NP] ();

   // Strap pins gathered per port
   assign strap_raw[0] = {i_strap_vlanprio_en_a, i_strap_portprio_a, i_strap_tag_add_a,
                          i_strap_tag_strip_a, i_strap_dual_queue_a};
   assign strap_raw[1] = {i_strap_vlanprio_en_b, i_strap_portprio_b, i_strap_tag_add_b,
                          i_strap_tag_strip_b, i_strap_dual_queue_b};
   assign strap_raw[2] = {i_strap_vlanprio_en_c, i_strap_portprio_c, i_strap_tag_add_c,
                          i_strap_tag_strip_c, i_strap_dual_queue_c};

   // Three-stage strap synchroniser, runs through reset
   always_ff @(posedge i_clk) begin
      strap_s1 <= strap_raw;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
   end

   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         // Strap level accepted once the last two stages agree
         always_ff @(posedge i_clk) begin
            if (strap_s2[p] == strap_s3[p]) begin
               strap_stable[p] <= strap_s3[p];
            end
         end

         assign hit[p] = (i_reg_addr == pqtc_pkg::PORT_CTRL_OFFS[p]);

         // Control register with strap-loaded reset
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               ctrl_reg[p][pqtc_pkg::BIT_STORM_EN] <= pqtc_pkg::RST_STORM_EN;
               ctrl_reg[p][pqtc_pkg::BIT_DSCP_EN] <= pqtc_pkg::RST_DSCP_EN;
               ctrl_reg[p][pqtc_pkg::BIT_VLANPRIO_EN] <= strap_stable[p][4];
               ctrl_reg[p][pqtc_pkg::BIT_PORTPRIO] <= strap_stable[p][3];
               ctrl_reg[p][pqtc_pkg::BIT_PRIO_CEILING] <= pqtc_pkg::RST_PRIO_CEILING;
               ctrl_reg[p][pqtc_pkg::BIT_TAG_ADD] <= strap_stable[p][2];
               ctrl_reg[p][pqtc_pkg::BIT_TAG_STRIP] <= strap_stable[p][1];
               ctrl_reg[p][pqtc_pkg::BIT_DUAL_QUEUE] <= strap_stable[p][0];
            end else if (i_reg_wr && hit[p]) begin
               ctrl_reg[p] <= i_reg_wdata;
            end
         end

         // Field decode onto the per-port control carrier
         assign u_ctrl[p].storm_en = ctrl_reg[p][pqtc_pkg::BIT_STORM_EN];
         assign u_ctrl[p].dscp_en = ctrl_reg[p][pqtc_pkg::BIT_DSCP_EN];
         assign u_ctrl[p].vlanprio_en = ctrl_reg[p][pqtc_pkg::BIT_VLANPRIO_EN];
         assign u_ctrl[p].port_high = ctrl_reg[p][pqtc_pkg::BIT_PORTPRIO];
         assign u_ctrl[p].prio_ceiling = ctrl_reg[p][pqtc_pkg::BIT_PRIO_CEILING];
         assign u_ctrl[p].tag_add = ctrl_reg[p][pqtc_pkg::BIT_TAG_ADD];
         assign u_ctrl[p].tag_strip = ctrl_reg[p][pqtc_pkg::BIT_TAG_STRIP];
         assign u_ctrl[p].dual_queue = ctrl_reg[p][pqtc_pkg::BIT_DUAL_QUEUE];

         // Storm limiter enable for ingress on this port
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               o_storm_en[p] <= 1'b0;
            end else begin
               o_storm_en[p] <= ctrl_reg[p][pqtc_pkg::BIT_STORM_EN];
            end
         end

         // Egress queue mode
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               o_dual_queue[p] <= 1'b0;
            end else begin
               o_dual_queue[p] <= ctrl_reg[p][pqtc_pkg::BIT_DUAL_QUEUE];
            end
         end

         // Ingress classifier
         pqtc_ing_cls u_cls (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .ctrl(u_ctrl[p]),
            .i_valid(i_ing_valid[p]),
            .i_tagged(i_ing_tagged[p]),
            .i_is_ip(i_ing_is_ip[p]),
            .i_dscp_high(i_ing_dscp_high[p]),
            .i_user_prio(i_ing_user_prio[p]),
            .i_dflt_prio(i_port_dflt_prio[p]),
            .o_valid(o_ing_valid[p]),
            .o_high(o_ing_high[p]),
            .o_user_prio(o_ing_user_prio[p])
         );

         // Egress valid pipeline
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               o_eg_valid[p] <= 1'b0;
            end else begin
               o_eg_valid[p] <= i_eg_valid[p];
            end
         end

         // Egress tag and queue decision
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               o_eg_add_tag[p] <= 1'b0;
               o_eg_strip_tag[p] <= 1'b0;
               o_eg_vid[p] <= '0;
               o_eg_queue_high[p] <= 1'b0;
            end else if (i_eg_valid[p]) begin
               o_eg_add_tag[p] <= ctrl_reg[p][pqtc_pkg::BIT_TAG_ADD]
                                  && !i_eg_rx_tagged[p]
                                  && (i_eg_src_port[p] < 2'(NP));
               o_eg_strip_tag[p] <= ctrl_reg[p][pqtc_pkg::BIT_TAG_STRIP]
                                    && i_eg_rx_tagged[p];
               if (i_eg_src_port[p] < 2'(NP)) begin
                  o_eg_vid[p] <= i_port_vid[i_eg_src_port[p]];
               end else begin
                  o_eg_vid[p] <= '0;
               end
               if (ctrl_reg[p][pqtc_pkg::BIT_DUAL_QUEUE]) begin
                  o_eg_queue_high[p] <= i_eg_high[p];
               end else begin
                  o_eg_queue_high[p] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Read multiplexer, unmapped addresses read as zero
   always_comb begin
      next_rdata = pqtc_pkg::UNMAPPED_RDATA;
      for (int k = 0; k < NP; k++) begin
         if (hit[k]) begin
            next_rdata = ctrl_reg[k];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
         end
      end
   end

endmodule : pqtc_top

//--- tb.sv
`timescale 1ns/1ps
module tb;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
   logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, o_reg_rvalid;
   logic [2:0] vp = 3'h5, pp = 3'h6, ta = 3'h5, ts = 3'h6, dq = 3'h5;
   logic [2:0][11:0] i_port_vid = 36'h333222111;
   logic [2:0][2:0] i_port_dflt_prio = 9'h092;
   logic [2:0] i_ing_valid = 3'h0, i_ing_tagged = 3'h0, i_ing_is_ip = 3'h0, i_ing_dscp_high = 3'h0;
   logic [2:0][2:0] i_ing_user_prio = 9'h000;
   logic [2:0] i_eg_valid = 3'h0, i_eg_rx_tagged = 3'h0, i_eg_high = 3'h0;
   logic [2:0][1:0] i_eg_src_port = 6'h00;
   logic [2:0] o_ing_valid, o_ing_high, o_storm_en, o_eg_valid, o_eg_add_tag;
   logic [2:0] o_eg_strip_tag, o_eg_queue_high, o_dual_queue;
   logic [2:0][2:0] o_ing_user_prio;
   logic [2:0][11:0] o_eg_vid;
   int err_count = 0;
   int n_tests = 0;
   always #20 i_clk = ~i_clk;
   pqtc_top u_pqtc_top (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
      .o_reg_rdata, .o_reg_rvalid, .i_strap_vlanprio_en_a(vp[0]), .i_strap_vlanprio_en_b(vp[1]),
      .i_strap_vlanprio_en_c(vp[2]), .i_strap_portprio_a(pp[0]), .i_strap_portprio_b(pp[1]),
      .i_strap_portprio_c(pp[2]), .i_strap_tag_add_a(ta[0]), .i_strap_tag_add_b(ta[1]),
      .i_strap_tag_add_c(ta[2]), .i_strap_tag_strip_a(ts[0]), .i_strap_tag_strip_b(ts[1]),
      .i_strap_tag_strip_c(ts[2]), .i_strap_dual_queue_a(dq[0]), .i_strap_dual_queue_b(dq[1]),
      .i_strap_dual_queue_c(dq[2]), .i_port_vid, .i_port_dflt_prio, .i_ing_valid, .i_ing_tagged,
      .i_ing_is_ip, .i_ing_dscp_high, .i_ing_user_prio, .o_ing_valid, .o_ing_high, .o_ing_user_prio,
      .o_storm_en, .i_eg_valid, .i_eg_src_port, .i_eg_rx_tagged, .i_eg_high, .o_eg_valid,
      .o_eg_add_tag, .o_eg_strip_tag, .o_eg_vid, .o_eg_queue_high, .o_dual_queue);
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tmo(input logic seen);
      if (seen !== 1'b1) begin
         err_count++;
         $display("wrong value handshake expected 1 seen %b", seen);
         end_sim();
      end
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_clk);
      i_reg_rd = 1'b0;
      for (int k = 0; k < 4 && o_reg_rvalid !== 1'b1; k++)
         @(negedge i_clk);
      tmo(o_reg_rvalid);
      chk("rdata", {4'h0, o_reg_rdata}, {4'h0, e});
   endtask : rd
   // Frame flags f are {tagged, is_ip, dscp_high}
   task automatic ing(input int p, input logic [7:0] r, input logic [2:0] f, input logic [2:0] u,
      input logic eh, input logic [2:0] eu);
      wr(pqtc_pkg::PORT_CTRL_OFFS[p], r);
      i_ing_valid[p] = 1'b1;
      {i_ing_tagged[p], i_ing_is_ip[p], i_ing_dscp_high[p]} = f;
      i_ing_user_prio[p] = u;
      @(negedge i_clk);
      i_ing_valid[p] = 1'b0;
      for (int k = 0; k < 4 && o_ing_valid[p] !== 1'b1; k++)
         @(negedge i_clk);
      tmo(o_ing_valid[p]);
      chk("ing_high", {11'h000, o_ing_high[p]}, {11'h000, eh});
      chk("ing_prio", {9'h000, o_ing_user_prio[p]}, {9'h000, eu});
   endtask : ing
   task automatic eg(input int p, input logic [7:0] r, input logic [1:0] s, input logic t,
      input logic h, input logic ea, input logic es, input logic eq);
      wr(pqtc_pkg::PORT_CTRL_OFFS[p], r);
      i_eg_valid[p] = 1'b1;
      i_eg_src_port[p] = s;
      i_eg_rx_tagged[p] = t;
      i_eg_high[p] = h;
      @(negedge i_clk);
      i_eg_valid[p] = 1'b0;
      for (int k = 0; k < 4 && o_eg_valid[p] !== 1'b1; k++)
         @(negedge i_clk);
      tmo(o_eg_valid[p]);
      chk("eg_add", {11'h000, o_eg_add_tag[p]}, {11'h000, ea});
      chk("eg_strip", {11'h000, o_eg_strip_tag[p]}, {11'h000, es});
      chk("eg_queue", {11'h000, o_eg_queue_high[p]}, {11'h000, eq});
      if (ea) chk("eg_vid", o_eg_vid[p], i_port_vid[s]);
      else if (s == 2'h3) chk("eg_vid", o_eg_vid[p], 12'h000);
   endtask : eg
   initial begin
      repeat (5) @(negedge i_clk);
      i_sys_rst = 1'b0;
      rd(8'h10, 8'h25);
      rd(8'h20, 8'h12);
      rd(8'h30, 8'h37);
      chk("storm", {9'h000, o_storm_en}, 12'h000);
      chk("dualq", {9'h000, o_dual_queue}, 12'h005);
      $display("test reset values done");
      wr(8'h10, 8'hA5);
      wr(8'h20, 8'h5A);
      wr(8'h30, 8'hFF);
      wr(8'h11, 8'h00);
      rd(8'h10, 8'hA5);
      rd(8'h20, 8'h5A);
      rd(8'h30, 8'hFF);
      rd(8'h40, 8'h00);
      chk("storm", {9'h000, o_storm_en}, 12'h005);
      chk("dualq", {9'h000, o_dual_queue}, 12'h005);
      $display("test register access done");
      ing(0, 8'h00, 3'h7, 3'h7, 1'b0, 3'h7);
      ing(1, 8'h10, 3'h4, 3'h0, 1'b1, 3'h0);
      ing(2, 8'h20, 3'h4, 3'h5, 1'b1, 3'h5);
      ing(2, 8'h30, 3'h4, 3'h1, 1'b0, 3'h1);
      ing(0, 8'h30, 3'h0, 3'h1, 1'b1, 3'h1);
      ing(0, 8'h40, 3'h3, 3'h0, 1'b1, 3'h0);
      ing(1, 8'h50, 3'h2, 3'h0, 1'b0, 3'h0);
      ing(2, 8'h28, 3'h4, 3'h5, 1'b0, 3'h2);
      ing(2, 8'h28, 3'h4, 3'h1, 1'b0, 3'h1);
      ing(0, 8'h68, 3'h7, 3'h5, 1'b1, 3'h2);
      $display("test ingress done");
      eg(0, 8'h05, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      eg(0, 8'h05, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      eg(1, 8'h02, 2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      eg(0, 8'h02, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      eg(2, 8'h04, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      eg(1, 8'h01, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      $display("test egress done");
      wr(8'h10, 8'hC8);
      wr(8'h30, 8'hFF);
      vp = ~vp;
      pp = ~pp;
      ta = ~ta;
      ts = ~ts;
      dq = ~dq;
      i_sys_rst = 1'b1;
      repeat (5) @(negedge i_clk);
      i_sys_rst = 1'b0;
      rd(8'h10, 8'h12);
      rd(8'h20, 8'h25);
      rd(8'h30, 8'h00);
      chk("storm", {9'h000, o_storm_en}, 12'h000);
      chk("dualq", {9'h000, o_dual_queue}, 12'h002);
      $display("test second reset done");
      end_sim();
   end
endmodule : tb
